// ---- core/bax_core.sv ----
// Overview of operation
// - add-to-file adds working register to file byte, sum to destination.
// - access bit clear uses access bank, set uses bank select register.
// - extended set, access clear, address at most 5Fh: indexed offset.
// - add-to-file updates negative, overflow, carry, digit carry, zero.
// - or-literal ORs immediate into working register, sets only N and Z.
// - or-file ORs working register with file byte, steered, N and Z only.
// - file address eight bits, destination and access single bits.
`timescale 1ns/1ps
`default_nettype none

module bax_core #(
   parameter int ADDR_W = 12
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              instr_valid_i,
   input  wire logic [15:0]       instr_i,
   input  wire logic              ext_set_en_i,
   input  wire logic [3:0]        bank_select_reg_i,
   input  wire logic [ADDR_W-1:0] index_base_i,
   input  wire logic [7:0]        file_rdata_i,
   output logic                   instr_ready_o,
   output logic                   file_rd_o,
   output logic                   file_wr_o,
   output logic [ADDR_W-1:0]      file_addr_o,
   output logic [7:0]             file_wdata_o,
   output logic [7:0]             wreg_o,
   output logic                   neg_flag_o,
   output logic                   overflow_flag_o,
   output logic                   carry_flag_o,
   output logic                   digit_carry_flag_o,
   output logic                   zero_flag_o,
   output logic                   illegal_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   bax_pkg::bax_phase_t phase_reg;
   logic [15:0]         instr_reg;
   logic [7:0]          wreg_reg;
   logic [4:0]          status_reg;
   logic [7:0]          opnd_reg;
   logic [7:0]          result_reg;
   logic [4:0]          status_next;
   logic [7:0]          result_next;
   logic [ADDR_W-1:0]   addr_reg;
   logic [ADDR_W-1:0]   addr_next;
   logic                illegal_reg;
   logic [8:0]          sum9;
   logic [4:0]          sum_lo;

   // decoded fields of the latched word
   bax_dec_if dif ();

   // opcode and field decoder
   bax_decoder i_bax_decoder (
      .instr_i (instr_reg),
      .dec     (dif.dec)
   );

   // ----------------------------------------------------------------
   // four-phase sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_reg <= bax_pkg::BAX_Q1;
      end else begin
         unique case (phase_reg)
            bax_pkg::BAX_Q1: if (instr_valid_i) phase_reg <= bax_pkg::BAX_Q2;
            bax_pkg::BAX_Q2: phase_reg <= bax_pkg::BAX_Q3;
            bax_pkg::BAX_Q3: phase_reg <= bax_pkg::BAX_Q4;
            bax_pkg::BAX_Q4: phase_reg <= bax_pkg::BAX_Q1;
         endcase
      end
   end

   // instruction word latched in the decode phase
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         instr_reg <= '0;
      end else if (phase_reg == bax_pkg::BAX_Q1 && instr_valid_i) begin
         instr_reg <= instr_i;
      end
   end

   // new word accepted only while waiting in the decode phase
   assign instr_ready_o = (phase_reg == bax_pkg::BAX_Q1);

   // ----------------------------------------------------------------
   // file address generation
   // ----------------------------------------------------------------
   always_comb begin
      if (!dif.acc_bit && ext_set_en_i && dif.fld <= bax_pkg::IDX_LIMIT)
      begin
         addr_next = index_base_i + ADDR_W'(dif.fld);
      end else if (dif.acc_bit) begin
         addr_next = ADDR_W'({bank_select_reg_i, dif.fld});
      end else if (dif.fld < bax_pkg::ACC_SPLIT) begin
         addr_next = ADDR_W'(dif.fld);
      end else begin
         addr_next = ADDR_W'({bax_pkg::ACC_HI_BANK, dif.fld});
      end
   end

   // address held for the write-back phase
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_reg <= '0;
      end else if (phase_reg == bax_pkg::BAX_Q2) begin
         addr_reg <= addr_next;
      end
   end

   // read strobe only for file operand opcodes
   assign file_addr_o = (phase_reg == bax_pkg::BAX_Q2) ? addr_next
                                                       : addr_reg;
   assign file_rd_o   = (phase_reg == bax_pkg::BAX_Q2) &&
                        (dif.op == bax_pkg::BAX_OP_ADD_FILE ||
                         dif.op == bax_pkg::BAX_OP_OR_FILE);

   // operand captured in the read phase
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         opnd_reg <= '0;
      end else if (phase_reg == bax_pkg::BAX_Q2) begin
         opnd_reg <= (dif.op == bax_pkg::BAX_OP_OR_LIT) ? dif.fld
                                                       : file_rdata_i;
      end
   end

   // ----------------------------------------------------------------
   // arithmetic and flags
   // ----------------------------------------------------------------
   // nine-bit sum for carry, nibble sum for digit carry
   assign sum9   = {1'b0, wreg_reg} + {1'b0, opnd_reg};
   assign sum_lo = {1'b0, wreg_reg[3:0]} + {1'b0, opnd_reg[3:0]};

   // result and flags for the process phase
   always_comb begin
      result_next = result_reg;
      status_next = status_reg;
      unique case (dif.op)
         bax_pkg::BAX_OP_ADD_FILE: begin
            result_next = sum9[7:0];
            status_next[bax_pkg::FLG_C]  = sum9[8];
            status_next[bax_pkg::FLG_DIG] = sum_lo[4];
            status_next[bax_pkg::FLG_OVFL] =
               (wreg_reg[7] == opnd_reg[7]) &&
               (sum9[7] != wreg_reg[7]);
            status_next[bax_pkg::FLG_N]  = sum9[7];
            status_next[bax_pkg::FLG_Z]  = (sum9[7:0] == 8'h00);
         end
         bax_pkg::BAX_OP_OR_LIT,
         bax_pkg::BAX_OP_OR_FILE: begin
            result_next = wreg_reg | opnd_reg;
            status_next[bax_pkg::FLG_N] = result_next[7];
            status_next[bax_pkg::FLG_Z] = (result_next == 8'h00);
         end
         bax_pkg::BAX_OP_NONE: begin
            result_next = result_reg;
         end
      endcase
   end

   // process phase: result and flags
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_reg <= '0;
         status_reg <= bax_pkg::STATUS_RST;
      end else if (phase_reg == bax_pkg::BAX_Q3) begin
         result_reg <= result_next;
         status_reg <= status_next;
      end
   end

   // ----------------------------------------------------------------
   // write-back to destination
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wreg_reg <= bax_pkg::WREG_RST;
      end else if (phase_reg == bax_pkg::BAX_Q4 &&
                   dif.op != bax_pkg::BAX_OP_NONE &&
                   (dif.op == bax_pkg::BAX_OP_OR_LIT ||
                    !dif.dest_file)) begin
         wreg_reg <= result_reg;
      end
   end

   // file write strobe and data for a file destination
   assign file_wr_o    = (phase_reg == bax_pkg::BAX_Q4) &&
                         dif.dest_file &&
                         (dif.op == bax_pkg::BAX_OP_ADD_FILE ||
                          dif.op == bax_pkg::BAX_OP_OR_FILE);
   assign file_wdata_o = result_reg;

   // unsupported opcode marker
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         illegal_reg <= 1'b0;
      end else if (phase_reg == bax_pkg::BAX_Q2) begin
         illegal_reg <= (dif.op == bax_pkg::BAX_OP_NONE);
      end
   end

   // registered outputs
   assign illegal_o          = illegal_reg;
   assign wreg_o             = wreg_reg;
   assign neg_flag_o         = status_reg[bax_pkg::FLG_N];
   assign overflow_flag_o    = status_reg[bax_pkg::FLG_OVFL];
   assign carry_flag_o       = status_reg[bax_pkg::FLG_C];
   assign digit_carry_flag_o = status_reg[bax_pkg::FLG_DIG];
   assign zero_flag_o        = status_reg[bax_pkg::FLG_Z];

endmodule

`default_nettype wire

// ---- core/bax_dec_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// decoded fields passed from decoder to the core
interface bax_dec_if;
   bax_pkg::bax_op_t op;
   logic             dest_file;
   logic             acc_bit;
   logic [7:0]       fld;

   modport dec  (output op, output dest_file, output acc_bit, output fld);
   modport core (input op, input dest_file, input acc_bit, input fld);
endinterface

`default_nettype wire

// ---- core/bax_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none

module bax_decoder (
   input  wire logic [15:0] instr_i,
   bax_dec_if.dec           dec
);

   // ----------------------------------------------------------------
   // opcode decode
   // ----------------------------------------------------------------
   always_comb begin
      dec.op = bax_pkg::BAX_OP_NONE;
      if (instr_i[bax_pkg::OPC6_MSB:bax_pkg::OPC6_LSB] ==
          bax_pkg::OPC_ADD_WREG_TO_FILE) begin
         dec.op = bax_pkg::BAX_OP_ADD_FILE;
      end else if (instr_i[bax_pkg::OPC6_MSB:bax_pkg::OPC6_LSB] ==
                   bax_pkg::OPC_OR_WREG_WITH_FILE) begin
         dec.op = bax_pkg::BAX_OP_OR_FILE;
      end else if (instr_i[bax_pkg::OPC6_MSB:bax_pkg::OPC8_LSB] ==
                   bax_pkg::OPC_OR_LITERAL_INTO_WREG) begin
         dec.op = bax_pkg::BAX_OP_OR_LIT;
      end
   end

   // field extraction
   assign dec.dest_file = instr_i[bax_pkg::DEST_BIT];
   assign dec.acc_bit   = instr_i[bax_pkg::ACC_BIT];
   assign dec.fld       = instr_i[7:0];

endmodule

`default_nettype wire

// ---- core/bax_pkg.sv ----
package bax_pkg;

   // ----------------------------------------------------------------
   // opcode fields
   // ----------------------------------------------------------------
   localparam logic [5:0] OPC_ADD_WREG_TO_FILE   = 6'h09;  // 0010 01da
   localparam logic [5:0] OPC_OR_WREG_WITH_FILE  = 6'h04;  // 0001 00da
   localparam logic [7:0] OPC_OR_LITERAL_INTO_WREG = 8'h09; // 0000 1001
   localparam int OPC6_MSB = 15;
   localparam int OPC6_LSB = 10;
   localparam int OPC8_LSB = 8;
   localparam int DEST_BIT = 9;
   localparam int ACC_BIT  = 8;

   // ----------------------------------------------------------------
   // addressing
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_LIMIT   = 8'h5F;
   localparam logic [7:0] ACC_SPLIT   = 8'h60;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   localparam logic [7:0] WREG_RST    = 8'h00;

   // ----------------------------------------------------------------
   // status flag positions
   // ----------------------------------------------------------------
   localparam int FLG_C    = 0;
   localparam int FLG_DIG  = 1;
   localparam int FLG_Z    = 2;
   localparam int FLG_OVFL = 3;
   localparam int FLG_N    = 4;
   localparam logic [4:0] STATUS_RST = 5'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BAX_OP_NONE,
      BAX_OP_ADD_FILE,
      BAX_OP_OR_LIT,
      BAX_OP_OR_FILE
   } bax_op_t;

   typedef enum {
      BAX_Q1,
      BAX_Q2,
      BAX_Q3,
      BAX_Q4
   } bax_phase_t;

endpackage

// ---- verification/bax_core_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module bax_core_checker #(
   parameter int ADDR_W = 12
) (
   input wire logic              sys_clk_i,
   input wire logic              rst_b_i,
   input wire logic              instr_valid_i,
   input wire logic [15:0]       instr_i,
   input wire logic              ext_set_en_i,
   input wire logic [3:0]        bank_select_reg_i,
   input wire logic [ADDR_W-1:0] index_base_i,
   input wire logic              instr_ready_o,
   input wire logic              file_rd_o,
   input wire logic              file_wr_o,
   input wire logic [ADDR_W-1:0] file_addr_o,
   input wire logic [7:0]        wreg_o,
   input wire logic              zero_flag_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // accepted word and file-operand opcode class
   logic take;
   logic fop;
   logic orl;
   assign take = instr_ready_o && instr_valid_i;
   assign fop  = instr_i[15:10] == 6'h09 || instr_i[15:10] == 6'h04;
   assign orl  = instr_i[15:8] == 8'h09;
   a_four_phase: assert property (
      take |=> !instr_ready_o [*3] ##1 instr_ready_o)
      else $error("instruction cycle not four phases");
   a_read_second: assert property (take && fop |=> file_rd_o)
      else $error("no file read in second phase");
   a_write_fourth: assert property (
      take && fop && instr_i[9] |-> ##3 file_wr_o)
      else $error("no file write in fourth phase");
   a_no_write_w: assert property (
      take && !instr_i[9] |=> !file_wr_o [*3])
      else $error("file written with working dest");
   a_access_low: assert property (
      take && fop && !instr_i[8] && !ext_set_en_i && instr_i[7:0] < 8'h60
      |=> file_addr_o == ADDR_W'($past(instr_i[7:0])))
      else $error("access bank address wrong");
   a_bank_select: assert property (take && fop && instr_i[8] |=>
      file_addr_o == ADDR_W'({$past(bank_select_reg_i), $past(instr_i[7:0])}))
      else $error("banked address wrong");
   a_indexed_addr: assert property (
      take && fop && !instr_i[8] && ext_set_en_i && instr_i[7:0] <= 8'h5F
      |=> file_addr_o == $past(index_base_i) + ADDR_W'($past(instr_i[7:0])))
      else $error("indexed address wrong");
   a_or_literal: assert property (take && orl |-> ##4
      wreg_o == ($past(wreg_o, 4) | $past(instr_i[7:0], 4)))
      else $error("or literal result wrong");
   a_or_zero: assert property (take && orl |-> ##3
      zero_flag_o == (($past(wreg_o, 3) | $past(instr_i[7:0], 3)) == 8'h00))
      else $error("or literal zero flag wrong");
endmodule
bind bax_core bax_core_checker #(.ADDR_W(ADDR_W)) i_bax_core_checker (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
   .instr_i(instr_i), .ext_set_en_i(ext_set_en_i),
   .bank_select_reg_i(bank_select_reg_i), .index_base_i(index_base_i),
   .instr_ready_o(instr_ready_o), .file_rd_o(file_rd_o),
   .file_wr_o(file_wr_o), .file_addr_o(file_addr_o), .wreg_o(wreg_o),
   .zero_flag_o(zero_flag_o));
`default_nettype wire

// ---- verification/bax_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bax_core_tb;
   logic        sys_clk, rst_b, valid, ext_en;
   logic        ready, rd, wr, n, ovf, c, dig, z, ill;
   logic [15:0] instr;
   logic [3:0]  bank;
   logic [11:0] base, addr;
   logic [7:0]  rdata, wdata, wreg;
   int          errors, tests_run;
   bax_core i_bax_core (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
      .instr_valid_i(valid), .instr_i(instr), .ext_set_en_i(ext_en),
      .bank_select_reg_i(bank), .index_base_i(base), .file_rdata_i(rdata),
      .instr_ready_o(ready), .file_rd_o(rd), .file_wr_o(wr),
      .file_addr_o(addr), .file_wdata_o(wdata), .wreg_o(wreg),
      .neg_flag_o(n), .overflow_flag_o(ovf), .carry_flag_o(c),
      .digit_carry_flag_o(dig), .zero_flag_o(z), .illegal_o(ill));
   bax_file_model i_bax_file_model (.sys_clk_i(sys_clk), .file_rd_i(rd),
      .file_wr_i(wr), .file_addr_i(addr), .file_wdata_i(wdata),
      .file_rdata_o(rdata));
   // free-running core clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic issue(input logic [15:0] ins, input logic e,
                        input logic [3:0] b);
      @(posedge sys_clk);
      instr  <= ins;
      ext_en <= e;
      bank   <= b;
      valid  <= 1'b1;
      @(posedge sys_clk);
      valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   task automatic run(input logic [15:0] ins, input logic e,
                      input logic [3:0] b, input logic [11:0] a,
                      input logic [7:0] fv, input logic [7:0] res,
                      input logic [4:0] flg);
      logic [7:0] w0;
      w0 = wreg;
      i_bax_file_model.mem[a] = fv;
      issue(ins, e, b);
      if (ins[9]) begin
         check(i_bax_file_model.mem[a], res);
         check(wreg, w0);
      end else begin
         check(wreg, res);
      end
      check({3'h0, n, ovf, c, dig, z}, {3'h0, flg});
   endtask
   task automatic conclude();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // main sequence: flags as {neg, overflow, carry, digit carry, zero}
   initial begin
      errors = 0;
      tests_run = 0;
      rst_b = 1'b0;
      valid = 1'b0;
      ext_en = 1'b0;
      instr = 16'h0000;
      bank = 4'h0;
      base = 12'h200;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      run(16'h0900, 1'b0, 4'h0, 12'h000, 8'h00, 8'h00, 5'h01);
      run(16'h0917, 1'b0, 4'h0, 12'h000, 8'h00, 8'h17, 5'h00);
      run(16'h2470, 1'b0, 4'h0, 12'hF70, 8'hC2, 8'hD9, 5'h10);
      run(16'h2710, 1'b0, 4'h3, 12'h310, 8'h27, 8'h00, 5'h07);
      run(16'h245F, 1'b1, 4'h0, 12'h25F, 8'h80, 8'h59, 5'h0C);
      run(16'h1260, 1'b1, 4'h0, 12'hF60, 8'h06, 8'h5F, 5'h0C);
      run(16'h11FF, 1'b1, 4'hA, 12'hAFF, 8'h80, 8'hD9, 5'h1C);
      run(16'h1210, 1'b0, 4'h0, 12'h010, 8'h24, 8'hFD, 5'h1C);
      issue(16'hFFFF, 1'b0, 4'h0);
      check({7'h00, ill}, 8'h01);
      check(wreg, 8'hD9);
      conclude();
   end
   // hang guard, well beyond the nine short instructions
   initial begin
      #(8 * 1000);
      errors++;
      conclude();
   end
endmodule
`default_nettype wire

// ---- verification/bax_file_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bax_file_model (
   input  wire logic        sys_clk_i,
   input  wire logic        file_rd_i,
   input  wire logic        file_wr_i,
   input  wire logic [11:0] file_addr_i,
   input  wire logic [7:0]  file_wdata_i,
   output logic [7:0]       file_rdata_o
);
   logic [7:0] mem [0:4095];
   logic [7:0] junk;
   // noise outside the read phase, flips every cycle
   initial junk = 8'h5A;
   always @(posedge sys_clk_i) junk <= ~junk;
   // byte offered only while the read strobe stands
   assign file_rdata_o = file_rd_i ? mem[file_addr_i] : junk;
   // write-back of a file destination
   always @(posedge sys_clk_i) begin
      if (file_wr_i) begin
         mem[file_addr_i] <= file_wdata_i;
      end
   end
endmodule
`default_nettype wire
